// ==== hw/onb_map.svh ====
// Register offsets, field positions and reset values for the burst control block
`ifndef ONB_MAP_SVH
`define ONB_MAP_SVH
`define ONB_ADDR_W          16
`define ONB_OFF_GAP         16'h14D2
`define ONB_OFF_REQUEST     16'h14D3
`define ONB_OFF_ENABLES     16'h14D4
`define ONB_OFF_TRIG_CTRL   16'h14D5
`define ONB_OFF_RETIME      16'h14D6
`define ONB_OFF_STATUS      16'h14DF
`define ONB_REQ_MODE_BIT    6
`define ONB_REQ_LEN_MSB     5
`define ONB_RETIME_BIT      0
`define ONB_CTRL_SEL_BIT    0
`define ONB_CTRL_SWTRIG_BIT 1
`define ONB_RST_BYTE        8'h00
`define ONB_PRBS_SEED       7'h7F
`define ONB_LANES           4
`endif

// ==== hw/onb_pkg.sv ====
// Types shared by the burst control block
package onb_pkg;
  typedef enum logic [1:0] {
    ONB_IDLE  = 2'b00,
    ONB_BURST = 2'b01,
    ONB_GAP   = 2'b10
  } onb_state_t;

  typedef struct packed {
    logic       burst_en;
    logic       prbs_en;
    logic       gap_mode;
    logic [5:0] len;
    logic [7:0] gap;
  } onb_lane_cfg_t;

  typedef struct packed {
    logic [15:0] addr;
    logic [7:0]  wdata;
    logic        wr;
    logic        rd;
  } onb_bus_t;
endpackage

// ==== hw/onb_lane.sv ====
// One output lane: burst gating, gap counting and pseudorandom source
`include "onb_map.svh"
module onb_lane
  import onb_pkg::*;
(
  // Clock and reset
  input  wire logic          ref_clk,
  input  wire logic          rst_n,
  // Configuration and trigger
  input  wire onb_lane_cfg_t cfg,
  input  wire logic          start,
  input  wire logic          level,
  // Divider output
  input  wire logic          div_in,
  // Result
  output logic               out_q,
  output logic               busy
);
  onb_state_t state_q;
  logic       div_d1_q;
  logic       pend_q;
  logic [5:0] cnt_q;
  logic [7:0] gcnt_q;
  logic [6:0] lfsr_q;
  logic       rise;
  logic       go;
  logic       enter;
  logic       src;

  assign rise  = div_in & ~div_d1_q;
  assign go    = pend_q | (cfg.gap_mode & level);
  assign enter = (state_q == ONB_IDLE) & cfg.burst_en & (cfg.len != 6'h00) & go & ~div_in;
  assign src   = cfg.prbs_en ? lfsr_q[6] : div_in;
  assign busy  = (state_q != ONB_IDLE);

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      div_d1_q <= 1'b0;
    end else begin
      div_d1_q <= div_in;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      pend_q <= 1'b0;
    end else if (start && cfg.burst_en) begin
      pend_q <= 1'b1;
    end else if (enter || !cfg.burst_en || cfg.len == 6'h00) begin
      pend_q <= 1'b0;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_q <= ONB_IDLE;
    end else if (!cfg.burst_en) begin
      state_q <= ONB_IDLE;
    end else begin
      case (state_q)
        ONB_IDLE: begin
          if (enter) begin
            state_q <= ONB_BURST;
          end
        end
        ONB_BURST: begin
          if (cnt_q == cfg.len && !div_in) begin
            state_q <= cfg.gap_mode ? ONB_GAP : ONB_IDLE;
          end
        end
        ONB_GAP: begin
          if (gcnt_q == cfg.gap) begin
            state_q <= ONB_IDLE;
          end
        end
        default: begin
          state_q <= ONB_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_q <= 6'h00;
    end else if (state_q != ONB_BURST) begin
      cnt_q <= 6'h00;
    end else if (rise) begin
      cnt_q <= cnt_q + 6'h01;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      gcnt_q <= 8'h00;
    end else if (state_q != ONB_GAP) begin
      gcnt_q <= 8'h00;
    end else if (rise) begin
      gcnt_q <= gcnt_q + 8'h01;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      lfsr_q <= `ONB_PRBS_SEED;
    end else if (rise) begin
      lfsr_q <= {lfsr_q[5:0], lfsr_q[6] ^ lfsr_q[5]};
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      out_q <= 1'b0;
    end else begin
      out_q <= cfg.burst_en ? ((state_q == ONB_BURST) & src) : src;
    end
  end

  AST_BURST_COUNT: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (state_q == ONB_BURST && cfg.burst_en) ##1 (state_q != ONB_BURST) |->
    ($past(cnt_q) == $past(cfg.len)))
    else $error("burst ended with wrong pulse count");

  AST_COUNT_BOUND: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (state_q == ONB_BURST) |-> (cnt_q <= cfg.len) || $changed(cfg.len))
    else $error("burst produced more pulses than programmed");

  AST_GAP_LEN: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (state_q == ONB_GAP && cfg.burst_en) ##1 (state_q != ONB_GAP) |->
    ($past(gcnt_q) == $past(cfg.gap)))
    else $error("gap ended with wrong length");

  AST_NO_GAP_EDGE: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (state_q == ONB_BURST && !cfg.gap_mode) ##1 (state_q != ONB_BURST) |->
    (state_q == ONB_IDLE))
    else $error("edge mode entered a gap");
endmodule

// ==== hw/onb_ctrl.sv ====
// Burst, pseudorandom and retime control for the four channel outputs
// Operation
// - Request mode 0: each trigger rising edge starts one burst.
// - Request mode 1: bursts repeat while the trigger stays high.
// - Each burst holds as many pulses as the 6-bit length field.
// - Per-output burst enable at bits 6,4,2,0 mutes output outside bursts.
// - Retime bit 0: trigger from multifunction pins or register, user selected.
// - Retime bit 1: trigger from the internal retiming block.
// - Gapped mode inserts a gap of 8-bit field divider cycles between bursts.
//
// Local design decision: the plain strobed port.
`include "onb_map.svh"
module onb_ctrl
  import onb_pkg::*;
(
  // Clock and reset
  input  wire logic        ref_clk,
  input  wire logic        rst_n,
  // Register port
  input  wire logic [15:0] reg_addr,
  input  wire logic [7:0]  reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic [7:0]       reg_rdata_q,
  // Trigger sources
  input  wire logic        multifunction_pins,
  input  wire logic        int_retime_trig,
  // Divider outputs: a_true, a_comp, b_true, b_comp
  input  wire logic [3:0]  div_clk_in,
  // Gated outputs in the same order
  output logic [3:0]       clk_out_q
);
  onb_bus_t      bus;
  onb_lane_cfg_t lane_cfg [`ONB_LANES];
  logic [7:0]    en_q;
  logic          retime_q;
  logic          mode_q;
  logic [5:0]    len_q;
  logic [7:0]    gap_q;
  logic          src_sel_q;
  logic          sw_trig_q;
  logic          mf_s1_q;
  logic          mf_s2_q;
  logic          trig_d;
  logic          trig_q;
  logic          trig_d1_q;
  logic          edge_start;
  logic [3:0]    busy;
  logic [7:0]    rdata_d;

  assign bus = '{addr: reg_addr, wdata: reg_wdata, wr: reg_wr, rd: reg_rd};

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      en_q      <= `ONB_RST_BYTE;
      retime_q  <= 1'b0;
      mode_q    <= 1'b0;
      len_q     <= 6'h00;
      gap_q     <= `ONB_RST_BYTE;
      src_sel_q <= 1'b0;
      sw_trig_q <= 1'b0;
    end else if (bus.wr) begin
      case (bus.addr)
        `ONB_OFF_ENABLES: begin
          en_q <= bus.wdata;
        end
        `ONB_OFF_RETIME: begin
          retime_q <= bus.wdata[`ONB_RETIME_BIT];
        end
        `ONB_OFF_REQUEST: begin
          mode_q <= bus.wdata[`ONB_REQ_MODE_BIT];
          len_q  <= bus.wdata[`ONB_REQ_LEN_MSB:0];
        end
        `ONB_OFF_GAP: begin
          gap_q <= bus.wdata;
        end
        `ONB_OFF_TRIG_CTRL: begin
          src_sel_q <= bus.wdata[`ONB_CTRL_SEL_BIT];
          sw_trig_q <= bus.wdata[`ONB_CTRL_SWTRIG_BIT];
        end
        default: begin
        end
      endcase
    end
  end

  // Read mux, unmapped reads as zero
  always_comb begin
    rdata_d = 8'h00;
    case (bus.addr)
      `ONB_OFF_ENABLES:   rdata_d = en_q;
      `ONB_OFF_RETIME:    rdata_d = {7'h00, retime_q};
      `ONB_OFF_REQUEST:   rdata_d = {1'b0, mode_q, len_q};
      `ONB_OFF_GAP:       rdata_d = gap_q;
      `ONB_OFF_TRIG_CTRL: rdata_d = {6'h00, sw_trig_q, src_sel_q};
      `ONB_OFF_STATUS:    rdata_d = {4'h0, busy};
      default:            rdata_d = 8'h00;
    endcase
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      reg_rdata_q <= 8'h00;
    end else if (bus.rd) begin
      reg_rdata_q <= rdata_d;
    end else begin
      reg_rdata_q <= 8'h00;
    end
  end

  // Pin trigger synchroniser
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      mf_s1_q <= 1'b0;
      mf_s2_q <= 1'b0;
    end else begin
      mf_s1_q <= multifunction_pins;
      mf_s2_q <= mf_s1_q;
    end
  end

  assign trig_d = retime_q ? int_retime_trig : (src_sel_q ? sw_trig_q : mf_s2_q);

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      trig_q    <= 1'b0;
      trig_d1_q <= 1'b0;
    end else begin
      trig_q    <= trig_d;
      trig_d1_q <= trig_q;
    end
  end

  assign edge_start = ~mode_q & trig_q & ~trig_d1_q;

  genvar gi;
  generate
    for (gi = 0; gi < `ONB_LANES; gi++) begin : g_lane
      assign lane_cfg[gi] = '{burst_en: en_q[2*gi], prbs_en: en_q[2*gi+1],
                              gap_mode: mode_q, len: len_q, gap: gap_q};
      onb_lane u_lane (
        .ref_clk (ref_clk),
        .rst_n   (rst_n),
        .cfg     (lane_cfg[gi]),
        .start   (edge_start),
        .level   (trig_q & mode_q),
        .div_in  (div_clk_in[gi]),
        .out_q   (clk_out_q[gi]),
        .busy    (busy[gi])
      );
    end
  endgenerate

  AST_EDGE_START: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (edge_start && en_q[0] && !busy[0]) ##1
    (en_q[0] && !busy[0] && len_q != 6'h00 && !div_clk_in[0]) |=> busy[0])
    else $error("edge did not start a burst");

  AST_LEVEL_REPEAT: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (mode_q && trig_q && en_q[0] && !busy[0] && len_q != 6'h00 && !div_clk_in[0])
    |=> busy[0] || !en_q[0] || !mode_q)
    else $error("level trigger did not repeat burst");

  AST_MUTED: assert property (@(posedge ref_clk) disable iff (!rst_n)
    ($past(en_q[0]) && !$past(busy[0])) |-> !clk_out_q[0])
    else $error("muted output toggled outside burst");

  AST_PASS_THROUGH: assert property (@(posedge ref_clk) disable iff (!rst_n)
    ($past(en_q[1:0]) == 2'b00) |-> clk_out_q[0] == $past(div_clk_in[0]))
    else $error("plain output does not follow divider");

  AST_RETIME_INT: assert property (@(posedge ref_clk) disable iff (!rst_n)
    retime_q |=> trig_q == $past(int_retime_trig))
    else $error("internal retime source not used");

  AST_RETIME_EXT: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (!retime_q && !src_sel_q) |=> trig_q == $past(mf_s2_q))
    else $error("pin retime source not used");

  AST_RESERVED_ZERO: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (bus.rd && bus.addr == `ONB_OFF_RETIME) |=> reg_rdata_q[7:1] == 7'h00)
    else $error("reserved bits read nonzero");

  AST_WRITE_TAKES: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (bus.wr && bus.addr == `ONB_OFF_ENABLES) ##1 (bus.rd && bus.addr == `ONB_OFF_ENABLES
     && !bus.wr) |=> reg_rdata_q == $past(bus.wdata, 2))
    else $error("enable write not read back");

  AST_RETIME_REG: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (!retime_q && src_sel_q) |=> trig_q == $past(sw_trig_q))
    else $error("register retime source not used");

  AST_LEN_ZERO: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (len_q == 6'h00 && !busy[0]) |=> !busy[0])
    else $error("zero length started a burst");

  AST_STATUS_BUSY: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (bus.rd && bus.addr == `ONB_OFF_STATUS) |=> reg_rdata_q == {4'h0, $past(busy)})
    else $error("status does not show lane activity");

  AST_READ_IDLE_ZERO: assert property (@(posedge ref_clk) disable iff (!rst_n)
    !bus.rd |=> reg_rdata_q == 8'h00)
    else $error("read data not cleared between reads");

  AST_REQ_RESERVED: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (bus.rd && bus.addr == `ONB_OFF_REQUEST) |=> reg_rdata_q[7] == 1'b0)
    else $error("request reserved bit reads nonzero");

  COV_EDGE_BURST: cover property (@(posedge ref_clk) disable iff (!rst_n)
    edge_start ##[1:20] busy[0]);
  COV_GAPPED: cover property (@(posedge ref_clk) disable iff (!rst_n)
    mode_q && busy[0] ##1 !busy[0] ##[1:200] busy[0]);
  COV_PRBS: cover property (@(posedge ref_clk) disable iff (!rst_n)
    en_q[1] && clk_out_q[0]);
  COV_ZERO_LEN_EDGE: cover property (@(posedge ref_clk) disable iff (!rst_n)
    edge_start && len_q == 6'h00);
  COV_INT_RETIME: cover property (@(posedge ref_clk) disable iff (!rst_n)
    retime_q && edge_start ##[1:20] busy[0]);
endmodule

// ==== verif/onb_far_model.sv ====
// Far side model: divide-by-eight dividers and per-lane output pulse counters
module onb_far_model (
  // Clock and reset
  input  wire logic       ref_clk,
  input  wire logic       rst_n,
  // Gated outputs and counter clear
  input  wire logic [3:0] clk_out_q,
  input  wire logic       clr,
  // Divider outputs and pulse counts
  output logic [3:0]      div_clk_in,
  output logic [7:0]      cnt [4]
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [2:0] div_q;
  logic [3:0] prev_q;
  assign div_clk_in = {4{div_q[2]}};
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      div_q  <= 3'h0;
      prev_q <= 4'h0;
      for (int i = 0; i < 4; i++) cnt[i] <= 8'h00;
    end else begin
      div_q  <= div_q + 3'h1;
      prev_q <= clk_out_q;
      for (int i = 0; i < 4; i++) begin
        if (clr) cnt[i] <= 8'h00;
        else if (clk_out_q[i] && !prev_q[i]) cnt[i] <= cnt[i] + 8'h01;
      end
    end
  end
endmodule

// ==== verif/output_nshot_burst_prbs_control_tb_top.sv ====
// Self-checking bench for the burst, pseudorandom and retime control
`include "onb_map.svh"
module output_nshot_burst_prbs_control_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  localparam logic [15:0] a_gap = `ONB_OFF_GAP;
  localparam logic [15:0] a_req = `ONB_OFF_REQUEST;
  localparam logic [15:0] a_en  = `ONB_OFF_ENABLES;
  localparam logic [15:0] a_trg = `ONB_OFF_TRIG_CTRL;
  localparam logic [15:0] a_rtm = `ONB_OFF_RETIME;
  localparam logic [15:0] a_sts = `ONB_OFF_STATUS;
  logic        ref_clk, rst_n, reg_wr, reg_rd, pin, iret, clr;
  logic [15:0] reg_addr;
  logic [7:0]  reg_wdata, reg_rdata_q;
  logic [3:0]  div_clk_in, clk_out_q;
  logic [7:0]  cnt [4];
  int          miscompares, n_checks, cycles;

  onb_ctrl dut (
    .ref_clk(ref_clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata_q(reg_rdata_q),
    .multifunction_pins(pin), .int_retime_trig(iret),
    .div_clk_in(div_clk_in), .clk_out_q(clk_out_q));
  onb_far_model far (
    .ref_clk(ref_clk), .rst_n(rst_n), .clk_out_q(clk_out_q), .clr(clr),
    .div_clk_in(div_clk_in), .cnt(cnt));

  initial begin
    ref_clk = 1'b0;
    forever #25 ref_clk = ~ref_clk;
  end

  task automatic tally_and_finish;
    $display("checks %0d miscompares %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 20000) begin
      miscompares++;
      tally_and_finish;
    end
  end

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge ref_clk);
    reg_wr    <= 1'b0;
  endtask
  task automatic rd(input logic [15:0] a, input logic [7:0] exp);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge ref_clk);
    reg_rd   <= 1'b0;
    @(negedge ref_clk);
    chk(reg_rdata_q, exp);
  endtask
  task automatic wr_rd(input logic [15:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge ref_clk);
    reg_wr    <= 1'b0;
    reg_rd    <= 1'b1;
    @(posedge ref_clk);
    reg_rd    <= 1'b0;
    @(negedge ref_clk);
    chk(reg_rdata_q, d);
  endtask
  task automatic idle(input int n);
    repeat (n) @(posedge ref_clk);
  endtask
  task automatic clear;
    @(posedge ref_clk);
    clr <= 1'b1;
    @(posedge ref_clk);
    clr <= 1'b0;
  endtask
  task automatic lanes(input logic [7:0] exp);
    @(negedge ref_clk);
    for (int i = 0; i < 4; i++) chk(cnt[i], exp);
  endtask
  task automatic in_range(input logic [7:0] lo, input logic [7:0] hi, input logic even);
    @(negedge ref_clk);
    for (int i = 0; i < 4; i++) begin
      chk({7'h00, (cnt[i] >= lo && cnt[i] <= hi && (!even || cnt[i][0] === 1'b0))}, 8'h01);
    end
  endtask

  initial begin
    rst_n = 1'b0;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 16'h0000;
    reg_wdata = 8'h00;
    pin = 1'b0;
    iret = 1'b0;
    clr = 1'b0;
    idle(2);
    rst_n <= 1'b1;
    rd(a_gap, 8'h00);
    rd(a_req, 8'h00);
    rd(a_en, 8'h00);
    rd(a_trg, 8'h00);
    rd(a_rtm, 8'h00);
    rd(a_sts, 8'h00);
    rd(16'h1234, 8'h00);
    wr(a_rtm, 8'hFF);
    rd(a_rtm, 8'h01);
    wr(a_rtm, 8'h00);
    wr(a_req, 8'h03);
    wr(a_en, 8'h55);
    wr(a_trg, 8'h01);
    clear;
    idle(100);
    lanes(8'h00);
    wr(a_trg, 8'h03);
    idle(10);
    rd(a_sts, 8'h0F);
    idle(200);
    lanes(8'h03);
    wr(a_trg, 8'h01);
    idle(100);
    lanes(8'h03);
    wr(a_req, 8'h00);
    clear;
    wr(a_trg, 8'h03);
    idle(100);
    lanes(8'h00);
    wr(a_trg, 8'h01);
    wr(a_req, 8'h05);
    wr(a_trg, 8'h00);
    clear;
    pin <= 1'b1;
    idle(200);
    lanes(8'h05);
    pin <= 1'b0;
    wr(a_rtm, 8'h01);
    wr(a_trg, 8'h03);
    clear;
    idle(100);
    lanes(8'h00);
    iret <= 1'b1;
    idle(200);
    lanes(8'h05);
    iret <= 1'b0;
    wr(a_trg, 8'h01);
    wr(a_rtm, 8'h00);
    wr(a_gap, 8'h04);
    wr(a_req, 8'h42);
    clear;
    wr(a_trg, 8'h03);
    idle(150);
    wr(a_trg, 8'h01);
    idle(100);
    in_range(8'h04, 8'h08, 1'b1);
    wr(a_en, 8'h00);
    clear;
    idle(80);
    lanes(8'h0A);
    wr_rd(a_en, 8'hAA);
    clear;
    idle(800);
    in_range(8'h08, 8'h31, 1'b0);
    tally_and_finish;
  end
endmodule
